// ==== rtl/mlc_consts.vh ====
`ifndef MLC_CONSTS_VH
`define MLC_CONSTS_VH

//------------------------------------------------------------
// Check arithmetic
//------------------------------------------------------------
`define MLC_CRC_PRESET   16'hFFFF
`define MLC_CRC_POLY     16'hA001
`define MLC_LRC_INIT     8'h00
`define MLC_CRC_STEPS    3'h7
`define MLC_CRC_STEP0    3'h0

//------------------------------------------------------------
// Characters and function codes
//------------------------------------------------------------
`define MLC_CH_COLON     8'h3A
`define MLC_CH_CR        8'h0D
`define MLC_CH_LF        8'h0A
`define MLC_CH_ZERO      8'h30
`define MLC_CH_NINE      8'h39
`define MLC_CH_UA        8'h41
`define MLC_CH_UF        8'h46
`define MLC_CH_LA        8'h61
`define MLC_CH_LF_HEX    8'h66
`define MLC_NIB_TEN      4'hA
`define MLC_FUNC_WMR     8'h10
`define MLC_ADDR_BCAST   8'h00

//------------------------------------------------------------
// Header byte positions
//------------------------------------------------------------
`define MLC_IDX_ADDR     3'h0
`define MLC_IDX_FUNC     3'h1
`define MLC_IDX_WC_HI    3'h4
`define MLC_IDX_WC_LO    3'h5
`define MLC_IDX_BCNT     3'h6
`define MLC_HDR_LAST     6'h06
`define MLC_HDR_BYTES    6'h07
`define MLC_IDX_MAX      6'h3F

//------------------------------------------------------------
// Reply sequence
//------------------------------------------------------------
`define MLC_SEQ_START    5'h00
`define MLC_SEQ_RTU_HDR  5'h06
`define MLC_SEQ_RTU_LO   5'h06
`define MLC_SEQ_RTU_HI   5'h07
`define MLC_SEQ_A_HDR    5'h0C
`define MLC_SEQ_A_CHK_HI 5'h0D
`define MLC_SEQ_A_CHK_LO 5'h0E
`define MLC_SEQ_A_CR     5'h0F
`define MLC_SEQ_A_LF     5'h10

//------------------------------------------------------------
// Timing at 50 MHz
//------------------------------------------------------------
`define MLC_SILENCE_MS   20'h0000A
`define MLC_CLK_KHZ      20'h0C350
`define MLC_SILENCE_CYC  (`MLC_SILENCE_MS * `MLC_CLK_KHZ)

`endif

// ==== rtl/mlc_fifo.v ====
`timescale 1ns/1ps
`default_nettype none

module mlc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             in_valid,
   input  wire [WIDTH-1:0] in_data,
   output wire             in_ready,
   output wire             out_valid,
   output wire [WIDTH-1:0] out_data,
   input  wire             out_ready
);

   //------------------------------------------------------------
   // Storage and pointers
   //------------------------------------------------------------
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   // Full and empty from the fill count, so depth need not be a power of two
   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rd_q];

   // Entry write
   always @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointer and count update
   always @(posedge clock) begin
      if (rst) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ==== rtl/mlc_frame_check.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mlc_consts.vh"

module mlc_frame_check #(
   parameter            SIL_W          = 20,
   parameter [SIL_W-1:0] SILENCE_CYCLES = `MLC_SILENCE_CYC,
   parameter            FIFO_DEPTH     = 32,
   parameter            FIFO_AW        = 5
) (
   input  wire       clock,
   input  wire       rst,
   input  wire       ascii_mode,
   input  wire       rx_valid,
   input  wire [7:0] rx_data,
   output reg        rx_ready_q,
   output reg        tx_valid_q,
   output reg  [7:0] tx_data_q,
   input  wire       tx_ready,
   output reg        frame_ok_q,
   output reg        check_error_q
);

   //------------------------------------------------------------
   // States
   //------------------------------------------------------------
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_SHIFT = 2'b01;
   localparam [1:0] ST_EVAL  = 2'b10;
   localparam [1:0] ST_GEN   = 2'b11;

   reg [1:0]       state_q;
   reg [15:0]      crc_q;
   reg [2:0]       step_q;
   reg             ret_gen_q;
   reg [7:0]       lrc_q;
   reg             in_frame_q;
   reg [7:0]       pend0_q;
   reg [7:0]       pend1_q;
   reg [1:0]       pend_cnt_q;
   reg [3:0]       hi_nib_q;
   reg             nib_q;
   reg [5:0]       byte_idx_q;
   // Eight entries so every three-bit index stays in range
   reg [7:0]       hdr_q [0:7];
   reg [4:0]       seq_q;
   reg [SIL_W-1:0] sil_q;

   //------------------------------------------------------------
   // Helper functions
   //------------------------------------------------------------
   // Hex character to {valid, nibble}; lower case is taken as well
   function [4:0] hex_dec;
      input [7:0] c;
      begin
         if (c >= `MLC_CH_ZERO && c <= `MLC_CH_NINE) begin
            hex_dec = {1'b1, c[3:0]};
         end else if ((c >= `MLC_CH_UA && c <= `MLC_CH_UF) ||
                      (c >= `MLC_CH_LA && c <= `MLC_CH_LF_HEX)) begin
            hex_dec = {1'b1, c[3:0] + 4'h9};
         end else begin
            hex_dec = 5'h00;
         end
      end
   endfunction

   // Nibble to upper-case hex character
   function [7:0] hex_enc;
      input [3:0] n;
      begin
         if (n < `MLC_NIB_TEN) begin
            hex_enc = `MLC_CH_ZERO + {4'h0, n};
         end else begin
            hex_enc = `MLC_CH_UA + {4'h0, n - `MLC_NIB_TEN};
         end
      end
   endfunction

   //------------------------------------------------------------
   // Combinational helpers
   //------------------------------------------------------------
   wire       accept   = rx_valid & rx_ready_q;
   wire       silent   = (sil_q >= SILENCE_CYCLES);
   wire [4:0] dec      = hex_dec(rx_data);
   wire [7:0] rx_byte  = {hi_nib_q, dec[3:0]};
   wire [7:0] lrc_neg  = `MLC_LRC_INIT - lrc_q;
   wire [4:0] a_k      = seq_q - 5'h01;
   wire [7:0] a_src    = hdr_q[a_k[3:1]];
   wire [7:0] wc_lo    = hdr_q[`MLC_IDX_WC_LO];
   wire [7:0] wc_hi    = hdr_q[`MLC_IDX_WC_HI];
   wire [16:0] wc_x2   = {wc_hi, wc_lo, 1'b0};
   wire       is_wmr   = (hdr_q[`MLC_IDX_FUNC] == `MLC_FUNC_WMR);
   wire       bc_ok    = !is_wmr || ((byte_idx_q >= `MLC_HDR_BYTES) &&
                         (wc_x2 == {9'h000, hdr_q[`MLC_IDX_BCNT]}));
   // earlier byte is the low half
   wire       rtu_match = (pend_cnt_q == 2'h2) && (crc_q == {pend0_q, pend1_q});
   wire       asc_match = (pend_cnt_q != 2'h0) && (pend0_q == lrc_neg);
   wire       match     = ascii_mode ? asc_match : rtu_match;

   // Reply byte for the current sequence step
   reg [7:0]  gen_byte;
   reg        gen_last;
   always @* begin
      gen_byte = 8'h00;
      gen_last = 1'b0;
      if (ascii_mode) begin
         if (seq_q == `MLC_SEQ_START) begin
            gen_byte = `MLC_CH_COLON;
         end else if (seq_q <= `MLC_SEQ_A_HDR) begin
            gen_byte = a_k[0] ? hex_enc(a_src[3:0]) : hex_enc(a_src[7:4]);
         end else if (seq_q == `MLC_SEQ_A_CHK_HI) begin
            gen_byte = hex_enc(lrc_neg[7:4]);
         end else if (seq_q == `MLC_SEQ_A_CHK_LO) begin
            gen_byte = hex_enc(lrc_neg[3:0]);
         end else if (seq_q == `MLC_SEQ_A_CR) begin
            gen_byte = `MLC_CH_CR;
         end else begin
            gen_byte = `MLC_CH_LF;
         end
         gen_last = (seq_q == `MLC_SEQ_A_LF);
      end else begin
         if (seq_q < `MLC_SEQ_RTU_HDR) begin
            gen_byte = hdr_q[seq_q[2:0]];
         end else if (seq_q == `MLC_SEQ_RTU_LO) begin
            gen_byte = crc_q[7:0];
         end else begin
            gen_byte = crc_q[15:8];
         end
         gen_last = (seq_q == `MLC_SEQ_RTU_HI);
      end
   end

   //------------------------------------------------------------
   // Reply FIFO and registered output stage
   //------------------------------------------------------------
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire       fifo_push = (state_q == ST_GEN);
   wire       push_ok   = fifo_push & fifo_in_ready;
   wire       fifo_pop  = fifo_out_valid & (!tx_valid_q | tx_ready);

   mlc_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (fifo_push),
      .in_data   (gen_byte),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_pop)
   );

   // Output stage keeps tx ports on flip-flops
   always @(posedge clock) begin
      if (rst) begin
         tx_valid_q <= 1'b0;
         tx_data_q  <= 8'h00;
      end else if (fifo_pop) begin
         tx_valid_q <= 1'b1;
         tx_data_q  <= fifo_out_data;
      end else if (tx_ready) begin
         tx_valid_q <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Line silence timer
   //------------------------------------------------------------
   // silence delimits RTU frames; saturates to avoid wrap
   always @(posedge clock) begin
      if (rst) begin
         sil_q <= SILENCE_CYCLES;
      end else if (accept) begin
         sil_q <= {SIL_W{1'b0}};
      end else if (!silent) begin
         sil_q <= sil_q + 1'b1;
      end
   end

   //------------------------------------------------------------
   // Frame receive, check and reply sequencer
   //------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         state_q       <= ST_IDLE;
         crc_q         <= `MLC_CRC_PRESET;
         step_q        <= `MLC_CRC_STEP0;
         ret_gen_q     <= 1'b0;
         lrc_q         <= `MLC_LRC_INIT;
         in_frame_q    <= 1'b0;
         pend0_q       <= 8'h00;
         pend1_q       <= 8'h00;
         pend_cnt_q    <= 2'h0;
         hi_nib_q      <= 4'h0;
         nib_q         <= 1'b0;
         byte_idx_q    <= 6'h00;
         seq_q         <= `MLC_SEQ_START;
         rx_ready_q    <= 1'b1;
         frame_ok_q    <= 1'b0;
         check_error_q <= 1'b0;
      end else begin
         frame_ok_q    <= 1'b0;
         check_error_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (accept && ascii_mode) begin
                  if (rx_data == `MLC_CH_COLON) begin
                     // Colon opens the frame and is kept out of the sum
                     in_frame_q <= 1'b1;
                     lrc_q      <= `MLC_LRC_INIT;
                     nib_q      <= 1'b0;
                     pend_cnt_q <= 2'h0;
                     byte_idx_q <= 6'h00;
                  end else if (rx_data == `MLC_CH_LF && in_frame_q) begin
                     in_frame_q <= 1'b0;
                     state_q    <= ST_EVAL;
                     rx_ready_q <= 1'b0;
                  end else if (rx_data == `MLC_CH_CR) begin
                     nib_q <= 1'b0;
                  end else if (dec[4] && in_frame_q) begin
                     // pair hex characters into one byte
                     nib_q    <= !nib_q;
                     hi_nib_q <= dec[3:0];
                     if (nib_q) begin
                        pend0_q    <= rx_byte;
                        pend_cnt_q <= 2'h1;
                        // last byte held back as the check field
                        if (pend_cnt_q != 2'h0) begin
                           lrc_q <= lrc_q + pend0_q;
                           if (byte_idx_q <= `MLC_HDR_LAST) begin
                              hdr_q[byte_idx_q[2:0]] <= pend0_q;
                           end
                           if (byte_idx_q != `MLC_IDX_MAX) begin
                              byte_idx_q <= byte_idx_q + 6'h01;
                           end
                        end
                     end
                  end else begin
                     in_frame_q <= 1'b0;
                  end
               end else if (accept) begin
                  // a byte after silence opens a new RTU frame
                  if (!in_frame_q || silent) begin
                     in_frame_q <= 1'b1;
                     crc_q      <= `MLC_CRC_PRESET;
                     byte_idx_q <= 6'h00;
                     pend_cnt_q <= 2'h1;
                     pend0_q    <= rx_data;
                  end else begin
                     pend0_q <= rx_data;
                     pend1_q <= pend0_q;
                     if (pend_cnt_q != 2'h2) begin
                        pend_cnt_q <= pend_cnt_q + 2'h1;
                     end else begin
                        // fold oldest byte into low half
                        crc_q      <= crc_q ^ {8'h00, pend1_q};
                        step_q     <= `MLC_CRC_STEP0;
                        ret_gen_q  <= 1'b0;
                        state_q    <= ST_SHIFT;
                        rx_ready_q <= 1'b0;
                        if (byte_idx_q <= `MLC_HDR_LAST) begin
                           hdr_q[byte_idx_q[2:0]] <= pend1_q;
                        end
                        if (byte_idx_q != `MLC_IDX_MAX) begin
                           byte_idx_q <= byte_idx_q + 6'h01;
                        end
                     end
                  end
               end else if (!ascii_mode && in_frame_q && silent) begin
                  in_frame_q <= 1'b0;
                  state_q    <= ST_EVAL;
                  rx_ready_q <= 1'b0;
               end
            end
            ST_SHIFT: begin
               // zero-fill shift, polynomial on a one out
               crc_q  <= crc_q[0] ? ({1'b0, crc_q[15:1]} ^ `MLC_CRC_POLY)
                                  : {1'b0, crc_q[15:1]};
               step_q <= step_q + 3'h1;
               if (step_q == `MLC_CRC_STEPS) begin
                  state_q    <= ret_gen_q ? ST_GEN : ST_IDLE;
                  rx_ready_q <= !ret_gen_q;
               end
            end
            ST_EVAL: begin
               // mismatch drops the frame with no reply
               if (match && bc_ok) begin
                  frame_ok_q <= 1'b1;
                  if (is_wmr && hdr_q[`MLC_IDX_ADDR] != `MLC_ADDR_BCAST) begin
                     state_q <= ST_GEN;
                     seq_q   <= `MLC_SEQ_START;
                     crc_q   <= `MLC_CRC_PRESET;
                     lrc_q   <= `MLC_LRC_INIT;
                  end else begin
                     state_q    <= ST_IDLE;
                     rx_ready_q <= 1'b1;
                  end
               end else begin
                  check_error_q <= 1'b1;
                  state_q       <= ST_IDLE;
                  rx_ready_q    <= 1'b1;
               end
            end
            ST_GEN: begin
               // fresh check computed over the echoed bytes
               if (push_ok) begin
                  seq_q <= seq_q + 5'h01;
                  if (gen_last) begin
                     state_q    <= ST_IDLE;
                     rx_ready_q <= 1'b1;
                  end else if (!ascii_mode && seq_q < `MLC_SEQ_RTU_HDR) begin
                     crc_q     <= crc_q ^ {8'h00, gen_byte};
                     step_q    <= `MLC_CRC_STEP0;
                     ret_gen_q <= 1'b1;
                     state_q   <= ST_SHIFT;
                  end else if (ascii_mode && seq_q != `MLC_SEQ_START &&
                               seq_q <= `MLC_SEQ_A_HDR && a_k[0]) begin
                     lrc_q <= lrc_q + a_src;
                  end
               end
            end
            default: begin
               state_q    <= ST_IDLE;
               rx_ready_q <= 1'b1;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== tb/mlc_checker_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module mlc_checker #(
   parameter             SIL_W          = 20,
   parameter [SIL_W-1:0] SILENCE_CYCLES = 20'h7A120
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       ascii_mode,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_ready_q,
   input wire logic       tx_valid_q,
   input wire logic [7:0] tx_data_q,
   input wire logic       tx_ready,
   input wire logic       frame_ok_q,
   input wire logic       check_error_q
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic [SIL_W-1:0] idle_q;

   // Quiet cycles since last byte taken; saturates so long gaps never wrap
   always @(posedge clock) begin
      if (rst) begin
         idle_q <= SILENCE_CYCLES;
      end else if (rx_valid && rx_ready_q) begin
         idle_q <= '0;
      end else if (idle_q != {SIL_W{1'b1}}) begin
         idle_q <= idle_q + 1'b1;
      end
   end

   property p_reset;
      @(posedge clock) disable iff (1'b0)
      rst |=> rx_ready_q && !tx_valid_q && !frame_ok_q && !check_error_q;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not at rest after reset");
   property p_fold;
      !ascii_mode && $fell(rx_ready_q) && $past(rx_valid) |-> !rx_ready_q [*8] ##1 rx_ready_q;
   endproperty
   a_fold: assert property (p_fold)
      else $error("byte fold not eight cycles");
   property p_ascii_end;
      ascii_mode && rx_valid && rx_ready_q && rx_data == 8'h0A |-> ##2 (frame_ok_q || check_error_q);
   endproperty
   a_ascii_end: assert property (p_ascii_end)
      else $error("no verdict two cycles after line feed");
   property p_rtu_sil;
      !ascii_mode && (frame_ok_q || check_error_q) |-> idle_q >= SILENCE_CYCLES;
   endproperty
   a_rtu_sil: assert property (p_rtu_sil)
      else $error("frame closed before the line went quiet");
   property p_pulse;
      frame_ok_q |-> !check_error_q ##1 !frame_ok_q;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("frame good pulse malformed");
   property p_err_quiet;
      check_error_q && !tx_valid_q |=> (!check_error_q && !tx_valid_q) [*8];
   endproperty
   a_err_quiet: assert property (p_err_quiet)
      else $error("reply or repeat after bad check");
   property p_eval;
      frame_ok_q || check_error_q |-> !$past(rx_ready_q);
   endproperty
   a_eval: assert property (p_eval)
      else $error("input open while checking frame");
   property p_tx_hold;
      tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("reply byte dropped while stalled");
endmodule

bind mlc_frame_check mlc_checker #(.SIL_W(SIL_W), .SILENCE_CYCLES(SILENCE_CYCLES)) u_chk (
   .clock(clock), .rst(rst), .ascii_mode(ascii_mode), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_ready_q(rx_ready_q), .tx_valid_q(tx_valid_q),
   .tx_data_q(tx_data_q), .tx_ready(tx_ready), .frame_ok_q(frame_ok_q),
   .check_error_q(check_error_q));

`default_nettype wire

// ==== tb/mlc_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module mlc_master_model (
   input  wire logic       clock,
   input  wire logic       slow,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       tx_ready
);
   logic [7:0] send_q[$];
   logic [7:0] got_q[$];
   logic [2:0] pace_q;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
      pace_q = 3'h0;
   end

   // Line side: one byte held until taken, then a quiet gap
   // gap and released data
   always @(posedge clock) begin
      if (rx_valid && rx_ready) begin
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
      end else if (!rx_valid && send_q.size() > 0) begin
         rx_valid <= 1'b1;
         rx_data <= send_q.pop_front();
      end
      if (tx_valid && tx_ready) begin
         got_q.push_back(tx_data);
      end
      // Slow master takes one byte in eight to back up the fifo
      tx_ready <= !slow || (pace_q == 3'h0);
      pace_q <= pace_q + 3'h1;
   end
endmodule

`default_nettype wire

// ==== tb/modbus_lrc_crc_check_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module modbus_lrc_crc_check_bench;
   logic        clock, rst, ascii_mode, slow, rx_valid, rx_ready_q;
   logic        tx_valid_q, tx_ready, frame_ok_q, check_error_q;
   logic [7:0]  rx_data, tx_data_q, wc, bad;
   logic [31:0] seed;
   logic [7:0]  f[$];
   int          mismatches, checks_done, oks, errs;
   bit          lower;

   mlc_frame_check #(.SILENCE_CYCLES(20'h00032)) u_dut (
      .clock(clock), .rst(rst), .ascii_mode(ascii_mode), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready_q(rx_ready_q), .tx_valid_q(tx_valid_q),
      .tx_data_q(tx_data_q), .tx_ready(tx_ready), .frame_ok_q(frame_ok_q),
      .check_error_q(check_error_q));
   mlc_master_model u_master (
      .clock(clock), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready_q), .tx_valid(tx_valid_q), .tx_data(tx_data_q),
      .tx_ready(tx_ready));

   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   // preset, fold then shift, eight steps
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int j = 0; j < 8; j++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction

   function automatic logic [7:0] lrc(input logic [7:0] b[$]);
      logic [7:0] s;
      s = 8'h00;
      foreach (b[i]) s = s + b[i];
      return 8'h00 - s;
   endfunction

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   // Frame bytes to line characters; bad flips bits of the check
   // high nibble first, low byte first
   task automatic wrap(input logic [7:0] b[$], input logic [7:0] bad, output logic [7:0] o[$]);
      logic [15:0] c;
      c = crc16(b);
      o = {};
      if (ascii_mode) begin
         b.push_back(lrc(b) ^ bad);
         o.push_back(8'h3A);
         foreach (b[i]) o = {o, hx(b[i][7:4]), hx(b[i][3:0])};
         o = {o, 8'h0D, 8'h0A};
      end else begin
         o = {b, c[7:0] ^ bad, c[15:8]};
      end
   endtask

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Send a frame, wait for the verdict, then compare any reply
   task automatic run(input string name, input logic [7:0] b[$], input logic [7:0] bad,
                      input logic ok, input logic rep);
      logic [7:0] s[$];
      logic [7:0] r[$];
      int n0, e0, k;
      @(negedge clock);
      n0 = oks;
      e0 = errs;
      u_master.got_q.delete();
      wrap(b, bad, s);
      // Lower-case hex digits on the line; the reply stays upper case
      if (lower && ascii_mode) begin
         foreach (s[i]) begin
            if (s[i] > 8'h40) s[i] = s[i] | 8'h20;
         end
      end
      r = {};
      if (rep) wrap(b[0:5], 8'h00, r);
      foreach (s[i]) u_master.send_q.push_back(s[i]);
      k = 0;
      while (oks == n0 && errs == e0 && k < 4000) begin
         @(negedge clock);
         k++;
      end
      check({name, " verdict"}, {14'h0, ok, !ok}, {14'h0, oks != n0, errs != e0});
      k = 0;
      while (u_master.got_q.size() < r.size() && k < 4000) begin
         @(negedge clock);
         k++;
      end
      repeat (40) @(negedge clock);
      check({name, " length"}, r.size(), u_master.got_q.size());
      foreach (r[i]) check({name, " reply"}, {8'h00, r[i]}, {8'h00, u_master.got_q[i]});
      $display("test %s done", name);
   endtask

   task end_sim();
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Verdict pulses counted for the running test
   always @(posedge clock) begin
      if (frame_ok_q === 1'b1) oks <= oks + 1;
      if (check_error_q === 1'b1) errs <= errs + 1;
   end

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Cut a hang well beyond the longest expected run
   initial begin
      #1500000;
      mismatches++;
      end_sim();
   end

   initial begin
      rst = 1'b1;
      ascii_mode = 1'b0;
      slow = 1'b0;
      seed = 32'hD914;
      {mismatches, checks_done} = '0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      check("crc sample", 16'hF76F, crc16('{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02}));
      check("lrc sample", 16'h00F6, {8'h00, lrc('{8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h01})});
      run("rtu read", '{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02}, 8'h00, 1'b1, 1'b0);
      @(posedge clock);
      ascii_mode <= 1'b1;
      run("ascii read", '{8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h01}, 8'h00, 1'b1, 1'b0);
      for (int m = 0; m < 2; m++) begin
         @(posedge clock);
         ascii_mode <= m[0];
         slow <= !m[0];
         lower = m[0];
         f = '{8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04, 8'h13, 8'h88, 8'h0F, 8'hA0};
         run("write multi", f, 8'h00, 1'b1, 1'b1);
         run("bad check", f, 8'h01, 1'b0, 1'b0);
         f[6] = 8'h05;
         run("bad count", f, 8'h00, 1'b0, 1'b0);
         f[0] = 8'h00;
         f[6] = 8'h04;
         run("broadcast", f, 8'h00, 1'b1, 1'b0);
      end
      for (int t = 0; t < 8; t++) begin
         @(posedge clock);
         ascii_mode <= rnd() > 8'h7F;
         slow <= rnd() > 8'h7F;
         lower = rnd() > 8'h7F;
         wc = {7'h00, rnd() > 8'h7F} + 8'h01;
         f = '{rnd() | 8'h01, 8'h10, rnd(), rnd(), 8'h00, wc, wc << 1};
         repeat (2 * wc) f.push_back(rnd());
         bad = (rnd() < 8'h40) ? 8'h20 : 8'h00;
         run("random", f, bad, bad == 8'h00, bad == 8'h00);
      end
      end_sim();
   end
endmodule

`default_nettype wire
